// File: verilog/dcs_pkg.sv
// constants, register map and carrier types for the channel size and pointer block
// assumes a single 250 MHz clock and an AXI4-Lite register port
`default_nettype none
package dcs_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 32'h0000_0004;
	localparam logic [ADDR_W-1:0] OFS_SRC_START = 32'h0000_0008;
	localparam logic [ADDR_W-1:0] OFS_DST_START = 32'h0000_000C;
	localparam logic [ADDR_W-1:0] OFS_SRC_LENGTH = 32'h0000_0010;
	localparam logic [ADDR_W-1:0] OFS_DST_LENGTH = 32'h0000_0014;
	localparam logic [ADDR_W-1:0] OFS_SRC_INDEX = 32'h0000_0018;
	localparam logic [ADDR_W-1:0] OFS_DST_INDEX = 32'h0000_001C;
	localparam logic [ADDR_W-1:0] OFS_CELL_LENGTH = 32'h0000_0020;
	localparam logic [ADDR_W-1:0] OFS_CELL_PROGRESS = 32'h0000_0024;
	localparam logic [ADDR_W-1:0] OFS_MATCH_BYTE = 32'h0000_0028;

	// control register fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_MATCH_EN_BIT = 1;
	// status register fields
	localparam int STATUS_BUSY_BIT = 0;

	// reset values
	localparam logic [7:0] LENGTH_RST = 8'h00;
	localparam logic [7:0] INDEX_RST = 8'h00;
	localparam logic [7:0] MATCH_RST = 8'h00;
	localparam logic [31:0] START_RST = 32'h0000_0000;
	localparam logic [8:0] FULL_LENGTH = 9'h100;

	// AXI4-Lite response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} dcs_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} dcs_axil_rsp_t;

	// byte-wide memory port toward the system bus
	typedef struct packed {
		logic rd_valid;
		logic [31:0] rd_addr;
		logic wr_valid;
		logic [31:0] wr_addr;
		logic [7:0] wr_data;
	} dcs_mem_req_t;

	typedef struct packed {
		logic rd_ready;
		logic rdata_valid;
		logic [7:0] rdata;
		logic wr_ready;
	} dcs_mem_rsp_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_RWAIT,
		ST_WRITE
	} dcs_state_t;
endpackage
`default_nettype wire

// File: verilog/dcs_channel.sv
// one byte-moving channel with its size, index, cell and match registers
// assumes one clock, a synchronous active-high reset, AXI4-Lite from software
// and a byte-wide memory port whose reads answer after the address is taken
//
// Summary of operation
// - destination length is 8 bits writable; 0 means 256 bytes.
// - source index is 8 bits, read-only, zero at reset.
// - destination index is 8 bits, read-only, zero at reset.
// - cell length is 8 bits writable; bytes per event, 0 means 256.
// - cell progress counts bytes moved since the last trigger, zero at reset.
// - with match mode on, a match clears source index and cell progress.
// - match byte ends the transfer on equality only in match mode.
// - block length is the larger of source and destination lengths.
// - a cell never exceeds the block; indices wrap at their own lengths.
// - writing a start address clears the matching index.
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dcs_channel (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire dcs_pkg::dcs_axil_req_t axil_req,
	output var dcs_pkg::dcs_axil_rsp_t axil_rsp,
	input wire logic cell_trigger,
	output var dcs_pkg::dcs_mem_req_t mem_req,
	input wire dcs_pkg::dcs_mem_rsp_t mem_rsp,
	output logic busy,
	output logic cell_done,
	output logic block_done,
	output logic match_hit
);
	import dcs_pkg::*;

	logic enable_q, match_en_q;
	logic [31:0] src_start_q, dst_start_q;
	logic [7:0] src_len_q, dst_len_q, cell_len_q, match_q;
	logic [7:0] src_idx_q, dst_idx_q;
	logic [8:0] cell_cnt_q, block_cnt_q;
	dcs_state_t state_q;
	logic [31:0] rd_addr_q, wr_addr_q;
	logic [7:0] wr_data_q;
	logic cell_done_q, block_done_q, match_hit_q;

	// bus slave state
	logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
	logic [31:0] aw_addr_q, w_data_q, rdata_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q;

	logic aw_fire, w_fire, wr_go, ar_fire;
	logic [31:0] wr_addr, wr_data;
	logic [3:0] wr_strb;

	// merge bytes of a write with the old value under the strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nv[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// zero-means-256 length decode
	function automatic logic [8:0] len9(input logic [7:0] v);
		return (v == 8'h00) ? FULL_LENGTH : {1'b0, v};
	endfunction

	// write channel handshakes: address and data are taken in either order
	assign axil_rsp.awready = !aw_have_q && !bvalid_q;
	assign axil_rsp.wready = !w_have_q && !bvalid_q;
	assign aw_fire = axil_req.awvalid && axil_rsp.awready;
	assign w_fire = axil_req.wvalid && axil_rsp.wready;
	assign wr_go = (aw_have_q || aw_fire) && (w_have_q || w_fire);
	assign wr_addr = aw_have_q ? aw_addr_q : axil_req.awaddr;
	assign wr_data = w_have_q ? w_data_q : axil_req.wdata;
	assign wr_strb = w_have_q ? w_strb_q : axil_req.wstrb;
	assign axil_rsp.bvalid = bvalid_q;
	assign axil_rsp.bresp = bresp_q;
	assign axil_rsp.arready = !rvalid_q;
	assign ar_fire = axil_req.arvalid && axil_rsp.arready;
	assign axil_rsp.rvalid = rvalid_q;
	assign axil_rsp.rdata = rdata_q;
	assign axil_rsp.rresp = rresp_q;

	// per-register write strobes
	logic wr_ctrl, wr_src_start, wr_dst_start, wr_src_len, wr_dst_len;
	logic wr_cell_len, wr_match, wr_mapped;
	assign wr_ctrl = wr_go && (wr_addr == OFS_CTRL);
	assign wr_src_start = wr_go && (wr_addr == OFS_SRC_START);
	assign wr_dst_start = wr_go && (wr_addr == OFS_DST_START);
	assign wr_src_len = wr_go && (wr_addr == OFS_SRC_LENGTH);
	assign wr_dst_len = wr_go && (wr_addr == OFS_DST_LENGTH);
	assign wr_cell_len = wr_go && (wr_addr == OFS_CELL_LENGTH);
	assign wr_match = wr_go && (wr_addr == OFS_MATCH_BYTE);
	// read-only accept
	// read-only registers answer OKAY and keep their value
	assign wr_mapped = (wr_addr == OFS_CTRL) || (wr_addr == OFS_STATUS)
		|| (wr_addr == OFS_SRC_START) || (wr_addr == OFS_DST_START)
		|| (wr_addr == OFS_SRC_LENGTH) || (wr_addr == OFS_DST_LENGTH)
		|| (wr_addr == OFS_SRC_INDEX) || (wr_addr == OFS_DST_INDEX)
		|| (wr_addr == OFS_CELL_LENGTH) || (wr_addr == OFS_CELL_PROGRESS)
		|| (wr_addr == OFS_MATCH_BYTE);

	// datapath terms for the byte mover
	logic byte_done, block_last, cell_last, match_now, start;
	logic [8:0] blk_len, cell_lim, src_inc, dst_inc;
	logic [7:0] src_idx_nx, dst_idx_nx;
	assign byte_done = (state_q == ST_WRITE) && mem_rsp.wr_ready;
	assign blk_len = (len9(src_len_q) > len9(dst_len_q)) ? len9(src_len_q) : len9(dst_len_q);
	assign cell_lim = (len9(cell_len_q) > blk_len) ? blk_len : len9(cell_len_q);
	assign block_last = byte_done && (9'(block_cnt_q + 9'h001) == blk_len);
	assign cell_last = byte_done && (9'(cell_cnt_q + 9'h001) == cell_lim);
	// compare in mode
	// the pattern is ignored unless match mode is on
	assign match_now = byte_done && match_en_q && (wr_data_q == match_q);
	assign start = (state_q == ST_IDLE) && cell_trigger && enable_q;
	assign src_inc = 9'({1'b0, src_idx_q} + 9'h001);
	assign dst_inc = 9'({1'b0, dst_idx_q} + 9'h001);
	assign src_idx_nx = (src_inc == len9(src_len_q)) ? INDEX_RST : src_inc[7:0];
	assign dst_idx_nx = (dst_inc == len9(dst_len_q)) ? INDEX_RST : dst_inc[7:0];

	// bus write side: hold halves, apply the write, post the response
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 32'h0000_0000;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else begin
				if (aw_fire) begin
					aw_have_q <= 1'b1;
					aw_addr_q <= axil_req.awaddr;
				end
				if (w_fire) begin
					w_have_q <= 1'b1;
					w_data_q <= axil_req.wdata;
					w_strb_q <= axil_req.wstrb;
				end
				if (bvalid_q && axil_req.bready) begin
					bvalid_q <= 1'b0;
				end
			end
		end
	end

	// bus read side: one cycle from address to data
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			// upper zero
			// upper bits of the byte-wide registers read as zero
			case (axil_req.araddr)
				OFS_CTRL: rdata_q <= 32'({match_en_q, enable_q});
				OFS_STATUS: rdata_q <= 32'(state_q != ST_IDLE);
				OFS_SRC_START: rdata_q <= src_start_q;
				OFS_DST_START: rdata_q <= dst_start_q;
				OFS_SRC_LENGTH: rdata_q <= {24'h000000, src_len_q};
				OFS_DST_LENGTH: rdata_q <= {24'h000000, dst_len_q};
				OFS_SRC_INDEX: rdata_q <= {24'h000000, src_idx_q};
				OFS_DST_INDEX: rdata_q <= {24'h000000, dst_idx_q};
				OFS_CELL_LENGTH: rdata_q <= {24'h000000, cell_len_q};
				OFS_CELL_PROGRESS: rdata_q <= {24'h000000, cell_cnt_q[7:0]};
				OFS_MATCH_BYTE: rdata_q <= {24'h000000, match_q};
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && axil_req.rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// software-writable configuration
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			src_start_q <= START_RST;
			dst_start_q <= START_RST;
			src_len_q <= LENGTH_RST;
			dst_len_q <= LENGTH_RST;
			cell_len_q <= LENGTH_RST;
			match_q <= MATCH_RST;
		end else begin
			if (wr_src_start) begin
				src_start_q <= merge(src_start_q, wr_data, wr_strb);
			end
			if (wr_dst_start) begin
				dst_start_q <= merge(dst_start_q, wr_data, wr_strb);
			end
			if (wr_src_len && wr_strb[0]) begin
				src_len_q <= wr_data[7:0];
			end
			if (wr_dst_len && wr_strb[0]) begin
				dst_len_q <= wr_data[7:0];
			end
			if (wr_cell_len && wr_strb[0]) begin
				cell_len_q <= wr_data[7:0];
			end
			if (wr_match && wr_strb[0]) begin
				match_q <= wr_data[7:0];
			end
		end
	end

	// control: hardware drops enable at block end or match, unless software writes it now
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			enable_q <= 1'b0;
			match_en_q <= 1'b0;
		end else if (wr_ctrl && wr_strb[0]) begin
			enable_q <= wr_data[CTRL_ENABLE_BIT];
			match_en_q <= wr_data[CTRL_MATCH_EN_BIT];
		end else if (block_last || match_now) begin
			enable_q <= 1'b0;
		end
	end

	// source index
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			src_idx_q <= INDEX_RST;
		end else if (wr_src_start) begin
			src_idx_q <= INDEX_RST;
		end else if (block_last || match_now) begin
			src_idx_q <= INDEX_RST;
		end else if (byte_done) begin
			src_idx_q <= src_idx_nx;
		end
	end

	// destination index
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dst_idx_q <= INDEX_RST;
		end else if (wr_dst_start) begin
			dst_idx_q <= INDEX_RST;
		end else if (block_last) begin
			dst_idx_q <= INDEX_RST;
		end else if (byte_done) begin
			dst_idx_q <= dst_idx_nx;
		end
	end

	// cell progress and block count; nine bits so a full 256 cell is seen
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cell_cnt_q <= 9'h000;
			block_cnt_q <= 9'h000;
		end else begin
			if (start || match_now) begin
				cell_cnt_q <= 9'h000;
			end else if (byte_done) begin
				cell_cnt_q <= 9'(cell_cnt_q + 9'h001);
			end
			if (block_last || match_now || wr_src_start || wr_dst_start) begin
				block_cnt_q <= 9'h000;
			end else if (byte_done) begin
				block_cnt_q <= 9'(block_cnt_q + 9'h001);
			end
		end
	end

	// mover sequence: read one byte, write it, repeat until cell, block or match ends
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			rd_addr_q <= 32'h0000_0000;
			wr_addr_q <= 32'h0000_0000;
			wr_data_q <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_READ;
						rd_addr_q <= 32'(src_start_q + {24'h000000, src_idx_q});
					end
				end
				ST_READ: begin
					if (mem_rsp.rd_ready) begin
						state_q <= ST_RWAIT;
					end
				end
				ST_RWAIT: begin
					if (mem_rsp.rdata_valid) begin
						state_q <= ST_WRITE;
						wr_data_q <= mem_rsp.rdata;
						wr_addr_q <= 32'(dst_start_q + {24'h000000, dst_idx_q});
					end
				end
				ST_WRITE: begin
					if (byte_done) begin
						if (cell_last || block_last || match_now) begin
							state_q <= ST_IDLE;
						end else begin
							state_q <= ST_READ;
							rd_addr_q <= 32'(src_start_q + {24'h000000, src_idx_nx});
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// one-cycle event pulses for the surrounding controller
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cell_done_q <= 1'b0;
			block_done_q <= 1'b0;
			match_hit_q <= 1'b0;
		end else begin
			cell_done_q <= cell_last;
			block_done_q <= block_last;
			match_hit_q <= match_now;
		end
	end

	// memory port; valids decode the state, payload comes from flops
	assign mem_req.rd_valid = (state_q == ST_READ);
	assign mem_req.rd_addr = rd_addr_q;
	assign mem_req.wr_valid = (state_q == ST_WRITE);
	assign mem_req.wr_addr = wr_addr_q;
	assign mem_req.wr_data = wr_data_q;
	assign busy = (state_q != ST_IDLE);
	assign cell_done = cell_done_q;
	assign block_done = block_done_q;
	assign match_hit = match_hit_q;
endmodule
`default_nettype wire

// File: sim/dcs_mem_model.sv
// byte memory standing on the channel's system bus side
// assumes one request at a time; slow halves the acceptance rate
`timescale 1ns/10ps
`default_nettype none
module dcs_mem_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire dcs_pkg::dcs_mem_req_t mem_req,
	output var dcs_pkg::dcs_mem_rsp_t mem_rsp
);
	import dcs_pkg::*;
	logic [7:0] mem [0:511];
	logic tick_q = 1'b0;
	logic go;
	int k;
	// every byte holds its own low address bits, so moved data is traceable
	initial begin
		mem_rsp = '0;
		for (k = 0; k < 512; k++) mem[k] = k[7:0];
	end
	assign go = !slow || tick_q;
	// ready never comes in the request's first cycle, so held requests are exercised
	always @(posedge ref_clk) begin
		tick_q <= !tick_q;
		mem_rsp.rd_ready <= !sys_rst && mem_req.rd_valid && !mem_rsp.rd_ready && go;
		mem_rsp.wr_ready <= !sys_rst && mem_req.wr_valid && !mem_rsp.wr_ready && go;
		mem_rsp.rdata_valid <= !sys_rst && mem_req.rd_valid && mem_rsp.rd_ready;
		// released data line inverts every cycle, so a stale copy shows only on alternate cycles
		if (mem_req.rd_valid && mem_rsp.rd_ready) mem_rsp.rdata <= mem[mem_req.rd_addr[8:0]];
		else mem_rsp.rdata <= ~mem_rsp.rdata;
		if (mem_req.wr_valid && mem_rsp.wr_ready) mem[mem_req.wr_addr[8:0]] <= mem_req.wr_data;
	end
endmodule
`default_nettype wire

// File: sim/dcs_channel_chk.sv
// port-level checks of the channel
// assumes one clock domain and a bench that holds bready and rready high
`timescale 1ns/10ps
`default_nettype none
module dcs_channel_chk (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire dcs_pkg::dcs_axil_req_t axil_req,
	input wire dcs_pkg::dcs_axil_rsp_t axil_rsp,
	input wire logic cell_trigger,
	input wire dcs_pkg::dcs_mem_req_t mem_req,
	input wire dcs_pkg::dcs_mem_rsp_t mem_rsp,
	input wire logic busy,
	input wire logic cell_done,
	input wire logic block_done,
	input wire logic match_hit
);
	import dcs_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_read_answer:
		assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
		else $error("read answer missing");
	a_ar_refused:
		assert property (axil_rsp.rvalid |-> !axil_rsp.arready) else $error("read taken early");
	a_aw_refused:
		assert property (axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready)
		else $error("write taken during response");
	a_idle_quiet:
		assert property (!busy |-> !mem_req.rd_valid && !mem_req.wr_valid)
		else $error("memory request while idle");
	a_rd_held:
		assert property (mem_req.rd_valid && !mem_rsp.rd_ready |=> mem_req.rd_valid
			&& $stable(mem_req.rd_addr)) else $error("read request dropped");
	a_wr_held:
		assert property (mem_req.wr_valid && !mem_rsp.wr_ready |=> mem_req.wr_valid
			&& $stable(mem_req.wr_addr) && $stable(mem_req.wr_data)) else $error("write dropped");
	a_rd_wait:
		assert property (mem_req.rd_valid && mem_rsp.rd_ready |=> !mem_req.rd_valid
			&& !mem_req.wr_valid) else $error("request before read data");
	a_wr_follows:
		assert property (mem_rsp.rdata_valid && busy |=> mem_req.wr_valid)
		else $error("write does not follow data");
	a_done_pulse:
		assert property (cell_done |=> !cell_done) else $error("cell done not a pulse");
	a_match_ends:
		assert property (match_hit |-> !busy) else $error("transfer runs past match");
	a_block_ends:
		assert property (block_done |-> !busy) else $error("transfer runs past block");
	c_cell: cover property (cell_done);
	c_block: cover property (block_done);
	c_match: cover property (match_hit);
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// bench: register tasks over AXI4-Lite, memory partner, checker bound
// assumes the partner's memory starts with each byte equal to the low eight bits of its address
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import dcs_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cell_trigger = 1'b0;
	logic slow = 1'b0;
	dcs_axil_req_t req = '0;
	dcs_axil_rsp_t rsp;
	dcs_mem_req_t mreq;
	dcs_mem_rsp_t mrsp;
	logic busy, cell_done, block_done, match_hit;
	int mismatches = 0;
	int compares = 0;
	int n_blk = 0;
	int n_hit = 0;
	int n_cel = 0;
	int i;
	always #2 ref_clk = ~ref_clk;
	dcs_channel dcs_channel_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .axil_req(req),
		.axil_rsp(rsp), .cell_trigger(cell_trigger), .mem_req(mreq), .mem_rsp(mrsp),
		.busy(busy), .cell_done(cell_done), .block_done(block_done), .match_hit(match_hit));
	dcs_mem_model dcs_mem_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow),
		.mem_req(mreq), .mem_rsp(mrsp));
	// pulse tallies; flags last one cycle so each edge counts once
	always @(posedge ref_clk) begin
		n_blk <= n_blk + int'(block_done === 1'b1);
		n_hit <= n_hit + int'(match_hit === 1'b1);
		n_cel <= n_cel + int'(cell_done === 1'b1);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// address and data offered together; each dropped at its own take edge
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		while (!(aw_ok && w_ok)) begin
			@(posedge ref_clk);
			if (!aw_ok && rsp.awready === 1'b1) begin
				aw_ok = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (!w_ok && rsp.wready === 1'b1) begin
				w_ok = 1'b1;
				req.wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (rsp.bvalid !== 1'b1);
		chk({30'h0, rsp.bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		do @(posedge ref_clk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge ref_clk); while (rsp.rvalid !== 1'b1);
		chk(rsp.rdata, e);
		chk({30'h0, rsp.rresp}, {30'h0, er});
	endtask
	// one trigger, then wait out the cell; the extra edges let pulses land
	task automatic run();
		cell_trigger <= 1'b1;
		@(posedge ref_clk);
		cell_trigger <= 1'b0;
		@(posedge ref_clk);
		while (busy !== 1'b0) @(posedge ref_clk);
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		req.bready = 1'b1;
		req.rready = 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		for (i = 0; i <= 40; i += 4) rd(32'(i), 32'h0, RESP_OKAY);
		rd(32'h2C, 32'h0, RESP_SLVERR);
		wr(32'h2C, 32'h1, RESP_SLVERR);
		// cell of 4 in a block of 6: source wraps at 3, destination does not
		wr(OFS_SRC_START, 32'h0, RESP_OKAY);
		wr(OFS_DST_START, 32'h100, RESP_OKAY);
		wr(OFS_SRC_LENGTH, 32'h3, RESP_OKAY);
		wr(OFS_DST_LENGTH, 32'h6, RESP_OKAY);
		rd(OFS_DST_LENGTH, 32'h6, RESP_OKAY);
		wr(OFS_CELL_LENGTH, 32'h4, RESP_OKAY);
		rd(OFS_CELL_LENGTH, 32'h4, RESP_OKAY);
		wr(OFS_MATCH_BYTE, 32'h1, RESP_OKAY);
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		slow <= 1'b1;
		run();
		rd(OFS_CELL_PROGRESS, 32'h4, RESP_OKAY);
		chk(n_cel, 1);
		rd(OFS_SRC_INDEX, 32'h1, RESP_OKAY);
		rd(OFS_DST_INDEX, 32'h4, RESP_OKAY);
		wr(OFS_SRC_INDEX, 32'h55, RESP_OKAY);
		wr(OFS_CELL_PROGRESS, 32'h55, RESP_OKAY);
		rd(OFS_SRC_INDEX, 32'h1, RESP_OKAY);
		rd(OFS_CELL_PROGRESS, 32'h4, RESP_OKAY);
		wr(OFS_DST_START, 32'h140, RESP_OKAY);
		rd(OFS_DST_INDEX, 32'h0, RESP_OKAY);
		wr(OFS_SRC_START, 32'h0, RESP_OKAY);
		rd(OFS_SRC_INDEX, 32'h0, RESP_OKAY);
		// cell of 256 clipped to the block of 6
		wr(OFS_CELL_LENGTH, 32'h0, RESP_OKAY);
		slow <= 1'b0;
		run();
		chk(n_blk, 1);
		chk(n_hit, 0);
		chk(n_cel, 2);
		rd(OFS_CTRL, 32'h0, RESP_OKAY);
		rd(OFS_CELL_PROGRESS, 32'h6, RESP_OKAY);
		for (i = 0; i < 6; i++) chk(32'(dcs_mem_model_i.mem[320 + i]), 32'(i % 3));
		chk(32'(dcs_mem_model_i.mem[326]), 32'h46);
		// match mode stops after the byte equal to the match byte
		wr(OFS_DST_START, 32'h180, RESP_OKAY);
		wr(OFS_SRC_LENGTH, 32'h8, RESP_OKAY);
		wr(OFS_DST_LENGTH, 32'h8, RESP_OKAY);
		wr(OFS_CELL_LENGTH, 32'h8, RESP_OKAY);
		wr(OFS_MATCH_BYTE, 32'h2, RESP_OKAY);
		wr(OFS_CTRL, 32'h3, RESP_OKAY);
		run();
		chk(n_hit, 1);
		chk(n_cel, 2);
		rd(OFS_CTRL, 32'h2, RESP_OKAY);
		chk(32'(dcs_mem_model_i.mem[386]), 32'h2);
		rd(OFS_SRC_INDEX, 32'h0, RESP_OKAY);
		rd(OFS_CELL_PROGRESS, 32'h0, RESP_OKAY);
		rd(OFS_DST_INDEX, 32'h3, RESP_OKAY);
		chk(32'(dcs_mem_model_i.mem[387]), 32'h83);
		wrap_up();
	end
	// watchdog well past the few hundred cycles the tests need
	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end
endmodule
bind dcs_channel dcs_channel_chk dcs_channel_chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.axil_req(axil_req), .axil_rsp(axil_rsp), .cell_trigger(cell_trigger),
	.mem_req(mem_req), .mem_rsp(mem_rsp), .busy(busy), .cell_done(cell_done),
	.block_done(block_done), .match_hit(match_hit));
`default_nettype wire
